// File: rtl/gmcc_pkg.sv
package gmcc_pkg;

	// operating modes
	typedef enum logic [1:0] {
		GMCC_INIT,
		GMCC_NORMAL,
		GMCC_SVC_PEND,
		GMCC_SERVICE
	} gmcc_mode_t;

	// kind of datagram handed to the framer
	typedef enum logic [2:0] {
		GMCC_DG_MEAS,
		GMCC_DG_PARTNO,
		GMCC_DG_SERIAL,
		GMCC_DG_CONFIG,
		GMCC_DG_EXTERR,
		GMCC_DG_INFO
	} gmcc_kind_t;

	// self-diagnostic fault conditions, one bit each
	typedef struct packed {
		logic supply;
		logic flash;
		logic ram;
		logic temp;
		logic overload;
		logic gyro_err;
		logic reference;
		logic spare;
	} gmcc_fault_t;

	// latency field, most significant byte sent first, 1 us per step
	typedef struct packed {
		logic [7:0] msb;
		logic [7:0] lsb;
	} gmcc_latency_t;

	// command characters
	localparam logic [7:0] GMCC_CR = 8'h0d;
	localparam int GMCC_BUF_LEN = 11;
	localparam logic [3:0] GMCC_CNT_OVF = 4'hc;
	localparam logic [87:0] GMCC_STR_SVC = 88'h53_45_52_56_49_43_45_4d_4f_44_45;
	localparam logic [3:0] GMCC_LEN_SVC = 4'hb;
	localparam logic [7:0] GMCC_CH_PART = 8'h4e;
	localparam logic [7:0] GMCC_CH_SERIAL = 8'h49;
	localparam logic [7:0] GMCC_CH_CONFIG = 8'h43;
	localparam logic [7:0] GMCC_CH_EXTERR = 8'h45;
	localparam logic [7:0] GMCC_CH_RESET = 8'h52;

	// register byte offsets
	localparam logic [7:0] GMCC_OFS_CTRL = 8'h00;
	localparam logic [7:0] GMCC_OFS_STATUS = 8'h04;
	localparam logic [7:0] GMCC_OFS_LASTERR = 8'h08;
	localparam logic [7:0] GMCC_OFS_ERRACC = 8'h0c;
	localparam logic [7:0] GMCC_OFS_LATENCY = 8'h10;

	// control register fields
	localparam int GMCC_CTRL_INCR = 0;
	localparam int GMCC_CTRL_EXIT = 1;
	localparam int GMCC_CTRL_EXIT_INIT = 2;

	// reset values
	localparam logic [15:0] GMCC_LATENCY_RST = 16'h0000;

endpackage

// File: rtl/gmcc_ctrl.sv
// Summary of operation
// - latency field is unsigned 16 bits, msb first, one microsecond per step
// - entering service mode sends the full configuration and identification listing
// - sampling and filtering keep running while in service mode
// - no measurement datagrams in service mode; those samples are discarded
// - external reset in service mode goes to init and reloads flash configuration
// - exit command carries a target: init mode or normal mode
// - exit to normal keeps modified configuration; reset later restores flash values
// - references, gyros, temperatures, memories and supply are checked continuously
// - any detected fault sets its matching bit in the status byte
// - status flags follow the current condition and are not latched
// - the last error seen in normal mode is kept for service mode
// - six normal commands: part, serial, config, error datagram, reset, maintenance entry
// - commands end with carriage return and execute only on it
// - no echo and no error messages in normal mode
// - only complete, correctly spelled commands act; anything else is ignored
// - with incremental angle, increment during a special datagram is dropped
// - part, serial or config datagram replaces next measurement datagram
// - error datagram reports all faults accumulated since the last clear
// - accumulated errors clear once the error datagram is fully sent
// - error datagram replaces the next and possibly several measurement datagrams
// - maintenance entry waits for a datagram in flight to finish
`timescale 1ns/1ps
module gmcc_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// received command bytes from the uart
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	// external reset pin
	input wire logic ext_reset_i,
	// self-diagnostics
	input wire gmcc_pkg::gmcc_fault_t fault_i,
	// datagram framer
	input wire logic slot_i,
	input wire logic tx_busy_i,
	input wire logic tx_done_i,
	output logic dg_start_o,
	output gmcc_pkg::gmcc_kind_t dg_kind_o,
	output gmcc_pkg::gmcc_fault_t status_o,
	output gmcc_pkg::gmcc_fault_t err_acc_o,
	output gmcc_pkg::gmcc_latency_t latency_o,
	output logic drop_incr_o,
	// system control
	output gmcc_pkg::gmcc_mode_t mode_o,
	output logic sampling_en_o,
	output logic discard_o,
	output logic cfg_reload_o,
	output logic unit_reset_o
);

	typedef struct packed {
		gmcc_pkg::gmcc_mode_t mode;
		gmcc_pkg::gmcc_kind_t kind;
		logic [2:0] pend;
		logic pend_err;
		logic drop_pend;
		logic [10:0][7:0] buf_q;
		logic [3:0] cnt;
		logic sync1;
		logic sync2;
		logic sync3;
		gmcc_pkg::gmcc_fault_t status;
		gmcc_pkg::gmcc_fault_t last_err;
		gmcc_pkg::gmcc_fault_t err_acc;
		logic incr;
		gmcc_pkg::gmcc_latency_t latency;
		logic ack;
		logic [31:0] rdat;
		logic start;
		logic reload;
		logic ureset;
		logic drop;
	} gmcc_state_t;

	gmcc_state_t state_reg;
	gmcc_state_t state_next;

	// one-letter command check: exactly one byte buffered
	function automatic logic gmcc_is_char(input logic [10:0][7:0] b, input logic [3:0] n,
		input logic [7:0] c);
		gmcc_is_char = (n == 4'h1) && (b[0] == c);
	endfunction

	logic wb_req;
	logic wb_wr;
	logic ext_rise;
	logic is_cr;
	logic exit_req;
	logic [31:0] rd_mux;

	assign wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
	// a write lands on the edge that sees ack high, while the master still holds it
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;
	assign ext_rise = state_reg.sync2 && !state_reg.sync3;
	assign is_cr = rx_valid_i && (rx_data_i == gmcc_pkg::GMCC_CR);
	// exit command from the service parser arrives as a control write
	assign exit_req = wb_wr && wb_sel_i[0] && (wb_adr_i == gmcc_pkg::GMCC_OFS_CTRL)
		&& wb_dat_i[gmcc_pkg::GMCC_CTRL_EXIT];

	// read mux, unmapped offsets answer zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (wb_adr_i)
			gmcc_pkg::GMCC_OFS_CTRL: rd_mux = {31'h0000_0000, state_reg.incr};
			gmcc_pkg::GMCC_OFS_STATUS: rd_mux = {22'h00_0000, state_reg.mode, state_reg.status};
			gmcc_pkg::GMCC_OFS_LASTERR: rd_mux = {24'h00_0000, state_reg.last_err};
			gmcc_pkg::GMCC_OFS_ERRACC: rd_mux = {24'h00_0000, state_reg.err_acc};
			gmcc_pkg::GMCC_OFS_LATENCY: rd_mux = {16'h0000, state_reg.latency};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.start = 1'b0;
		state_next.reload = 1'b0;
		state_next.ureset = 1'b0;
		state_next.drop = 1'b0;

		// pin synchroniser and edge detect on the second stage only
		state_next.sync1 = ext_reset_i;
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;

		// status is the live condition of this cycle, never held
		state_next.status = fault_i;
		// set wins over the clear at the end of an error datagram
		if (tx_done_i && (state_reg.kind == gmcc_pkg::GMCC_DG_EXTERR)) begin
			state_next.err_acc = fault_i;
		end else begin
			state_next.err_acc = state_reg.err_acc | fault_i;
		end
		if ((state_reg.mode == gmcc_pkg::GMCC_NORMAL) && (fault_i != 8'h00)) begin
			state_next.last_err = fault_i;
		end

		// bus slave, one wait state, ack for one cycle
		state_next.ack = wb_req;
		if (wb_req) begin
			state_next.rdat = rd_mux;
		end
		if (wb_wr && (wb_adr_i == gmcc_pkg::GMCC_OFS_CTRL) && wb_sel_i[0]) begin
			state_next.incr = wb_dat_i[gmcc_pkg::GMCC_CTRL_INCR];
		end
		if (wb_wr && (wb_adr_i == gmcc_pkg::GMCC_OFS_LATENCY)) begin
			if (wb_sel_i[1]) begin
				state_next.latency.msb = wb_dat_i[15:8];
			end
			if (wb_sel_i[0]) begin
				state_next.latency.lsb = wb_dat_i[7:0];
			end
		end

		// datagram slots in normal mode; placed ahead of command decode so that
		// a request arriving on the edge that serves an older one is not lost
		if (state_reg.mode == gmcc_pkg::GMCC_NORMAL && slot_i && !tx_busy_i) begin
			// a long error datagram keeps tx_busy_i high, so later slots are skipped
			state_next.start = 1'b1;
			if (state_reg.pend[0]) begin
				state_next.kind = gmcc_pkg::GMCC_DG_PARTNO;
				state_next.pend[0] = 1'b0;
				state_next.drop_pend = state_reg.incr;
			end else if (state_reg.pend[1]) begin
				state_next.kind = gmcc_pkg::GMCC_DG_SERIAL;
				state_next.pend[1] = 1'b0;
				state_next.drop_pend = state_reg.incr;
			end else if (state_reg.pend[2]) begin
				state_next.kind = gmcc_pkg::GMCC_DG_CONFIG;
				state_next.pend[2] = 1'b0;
				state_next.drop_pend = state_reg.incr;
			end else if (state_reg.pend_err) begin
				state_next.kind = gmcc_pkg::GMCC_DG_EXTERR;
				state_next.pend_err = 1'b0;
				state_next.drop_pend = state_reg.incr;
			end else begin
				state_next.kind = gmcc_pkg::GMCC_DG_MEAS;
				// increment built up during the special datagram is lost
				state_next.drop = state_reg.drop_pend;
				state_next.drop_pend = 1'b0;
			end
		end

		// command collection, normal mode only; nothing is ever echoed
		if (state_reg.mode == gmcc_pkg::GMCC_NORMAL && rx_valid_i) begin
			if (is_cr) begin
				state_next.cnt = 4'h0;
				state_next.buf_q = '0;
				// exact, upper-case spelling only; else silently dropped
				if (gmcc_is_char(state_reg.buf_q, state_reg.cnt, gmcc_pkg::GMCC_CH_PART)) begin
					state_next.pend[0] = 1'b1;
				end
				if (gmcc_is_char(state_reg.buf_q, state_reg.cnt, gmcc_pkg::GMCC_CH_SERIAL)) begin
					state_next.pend[1] = 1'b1;
				end
				if (gmcc_is_char(state_reg.buf_q, state_reg.cnt, gmcc_pkg::GMCC_CH_CONFIG)) begin
					state_next.pend[2] = 1'b1;
				end
				if (gmcc_is_char(state_reg.buf_q, state_reg.cnt, gmcc_pkg::GMCC_CH_EXTERR)) begin
					state_next.pend_err = 1'b1;
				end
				if (gmcc_is_char(state_reg.buf_q, state_reg.cnt, gmcc_pkg::GMCC_CH_RESET)) begin
					state_next.mode = gmcc_pkg::GMCC_INIT;
					state_next.ureset = 1'b1;
				end
				if ((state_reg.cnt == gmcc_pkg::GMCC_LEN_SVC)
					&& (state_reg.buf_q == gmcc_pkg::GMCC_STR_SVC)) begin
					state_next.mode = gmcc_pkg::GMCC_SVC_PEND;
				end
			end else if (state_reg.cnt != gmcc_pkg::GMCC_CNT_OVF) begin
				// shift in; an overlong line saturates and never matches
				state_next.buf_q = {state_reg.buf_q[9:0], rx_data_i};
				state_next.cnt = state_reg.cnt + 4'h1;
			end
		end

		// maintenance entry waits for the frame in flight; a start pulse counts
		// as in flight because the framer raises busy only a cycle later
		if (state_reg.mode == gmcc_pkg::GMCC_SVC_PEND && !tx_busy_i && !state_reg.start) begin
			state_next.mode = gmcc_pkg::GMCC_SERVICE;
			state_next.kind = gmcc_pkg::GMCC_DG_INFO;
			state_next.start = 1'b1;
			state_next.pend = 3'h0;
			state_next.pend_err = 1'b0;
		end

		// leaving service mode by command, target chosen by the caller
		if (state_reg.mode == gmcc_pkg::GMCC_SERVICE && exit_req) begin
			if (wb_dat_i[gmcc_pkg::GMCC_CTRL_EXIT_INIT]) begin
				state_next.mode = gmcc_pkg::GMCC_INIT;
			end else begin
				// no reload: modified settings stay in force until reset
				state_next.mode = gmcc_pkg::GMCC_NORMAL;
				state_next.kind = gmcc_pkg::GMCC_DG_MEAS;
			end
		end

		// init reloads flash for one cycle, then runs normally
		if (state_reg.mode == gmcc_pkg::GMCC_INIT) begin
			state_next.reload = 1'b1;
			state_next.mode = gmcc_pkg::GMCC_NORMAL;
			state_next.kind = gmcc_pkg::GMCC_DG_MEAS;
			state_next.cnt = 4'h0;
			state_next.buf_q = '0;
		end

		// external reset overrides any mode change, in any mode
		if (ext_rise) begin
			state_next.mode = gmcc_pkg::GMCC_INIT;
			state_next.pend = 3'h0;
			state_next.pend_err = 1'b0;
			state_next.drop_pend = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.mode <= gmcc_pkg::GMCC_INIT;
			state_reg.kind <= gmcc_pkg::GMCC_DG_MEAS;
			state_reg.latency <= gmcc_pkg::GMCC_LATENCY_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdat;
	assign dg_start_o = state_reg.start;
	assign dg_kind_o = state_reg.kind;
	assign status_o = state_reg.status;
	assign err_acc_o = state_reg.err_acc;
	assign latency_o = state_reg.latency;
	assign drop_incr_o = state_reg.drop;
	assign mode_o = state_reg.mode;
	// filters never stop; service mode only throws the samples away
	assign sampling_en_o = 1'b1;
	assign discard_o = (state_reg.mode == gmcc_pkg::GMCC_SERVICE)
		|| (state_reg.mode == gmcc_pkg::GMCC_SVC_PEND);
	assign cfg_reload_o = state_reg.reload;
	assign unit_reset_o = state_reg.ureset;

endmodule

// File: tb/gmcc_ctrl_assertions.sv
`timescale 1ns/1ps
module gmcc_ctrl_assertions (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus and pins watched
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic ext_reset_i,
	input wire logic slot_i,
	input wire logic tx_busy_i,
	input wire logic dg_start_o,
	input wire logic discard_o,
	input wire logic cfg_reload_o,
	input wire gmcc_pkg::gmcc_fault_t fault_i,
	input wire gmcc_pkg::gmcc_fault_t status_o,
	input wire gmcc_pkg::gmcc_fault_t err_acc_o,
	input wire gmcc_pkg::gmcc_kind_t dg_kind_o,
	input wire gmcc_pkg::gmcc_mode_t mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// entry steps: pending with an idle framer, then the listing goes out
	sequence s_pend_idle;
		mode_o == gmcc_pkg::GMCC_SVC_PEND && !tx_busy_i && !dg_start_o;
	endsequence
	sequence s_info_out;
		mode_o == gmcc_pkg::GMCC_SERVICE ##[0:1] (dg_start_o && dg_kind_o == gmcc_pkg::GMCC_DG_INFO);
	endsequence
	// bus answer timing
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	// guard the first cycle, status is still zero from reset
	chk_status_live: assert property (!$past(rst_i) |-> status_o == $past(fault_i))
		else $error("status not live");
	chk_acc_holds: assert property (!$past(rst_i) |-> (err_acc_o & $past(fault_i)) == $past(fault_i))
		else $error("fault not accumulated");
	// past mode, since a slot taken just before entry may still start
	chk_svc_quiet: assert property ($past(discard_o) |-> !(dg_start_o && dg_kind_o == gmcc_pkg::GMCC_DG_MEAS))
		else $error("measurement in service");
	chk_slot_start: assert property (mode_o == gmcc_pkg::GMCC_NORMAL && slot_i && !tx_busy_i |=> dg_start_o)
		else $error("slot not served");
	chk_enter_svc: assert property (s_pend_idle |=> s_info_out)
		else $error("no info listing");
	chk_pend_wait: assert property (mode_o == gmcc_pkg::GMCC_SVC_PEND && (tx_busy_i || dg_start_o)
		|=> mode_o != gmcc_pkg::GMCC_SERVICE) else $error("entered during frame");
	chk_init_load: assert property (mode_o == gmcc_pkg::GMCC_INIT |-> ##[1:2] cfg_reload_o)
		else $error("no reload");
	chk_ext_init: assert property ($rose(ext_reset_i) |-> ##[2:4] mode_o == gmcc_pkg::GMCC_INIT)
		else $error("ext reset ignored");
endmodule
bind gmcc_ctrl gmcc_ctrl_assertions gmcc_ctrl_assertions_i (.*);

// File: tb/gmcc_framer_model.sv
`timescale 1ns/1ps
module gmcc_framer_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// start request from the block
	input wire logic dg_start_i,
	input wire gmcc_pkg::gmcc_kind_t dg_kind_i,
	// framer status
	output logic slot_o,
	output logic tx_busy_o,
	output logic tx_done_o
);
	int tick;
	int left;
	// slot every 40 cycles; frames fill most of a slot so a late command lands mid-frame,
	// and the error datagram is slow, 90 cycles, and outlasts two slots
	always @(posedge clk_i) begin
		if (rst_i) begin
			tick <= 0;
			left <= 0;
			slot_o <= 0;
			tx_busy_o <= 0;
			tx_done_o <= 0;
		end else begin
			tick <= (tick == 39) ? 0 : tick + 1;
			slot_o <= (tick == 39);
			tx_done_o <= (left == 1);
			tx_busy_o <= dg_start_i || left > 1;
			if (dg_start_i) begin
				left <= (dg_kind_i == gmcc_pkg::GMCC_DG_EXTERR) ? 90 : 30;
			end else if (left != 0) begin
				left <= left - 1;
			end
		end
	end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, rx_valid_i = 0, ext_reset_i = 0, seen, dr;
	logic [7:0] rx_data_i = 8'h00;
	gmcc_pkg::gmcc_fault_t fault_i = '0, f, status_o, err_acc_o;
	logic wb_ack_o, slot_i, tx_busy_i, tx_done_i, dg_start_o, drop_incr_o;
	logic sampling_en_o, discard_o, cfg_reload_o, unit_reset_o;
	logic [31:0] wb_dat_o, rd;
	logic [15:0] lat;
	gmcc_pkg::gmcc_kind_t dg_kind_o, k;
	gmcc_pkg::gmcc_latency_t latency_o;
	gmcc_pkg::gmcc_mode_t mode_o;
	int miscompares = 0, samples_checked = 0;
	string cmds[3] = '{"N", "I", "C"};
	string bad[3] = '{"n", "NX", ""};
	string svc;
	always #10 clk_i = ~clk_i;
	gmcc_ctrl gmcc_ctrl_i (.*);
	gmcc_framer_model gmcc_framer_model_i (.clk_i(clk_i), .rst_i(rst_i), .dg_start_i(dg_start_o),
		.dg_kind_i(dg_kind_o), .slot_o(slot_i), .tx_busy_o(tx_busy_i), .tx_done_o(tx_done_i));
	// one classic cycle; no fixed answer time is assumed
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n >= 50) miscompares++;
	endtask
	// host bytes, closed by carriage return; start just after a slot so the
	// terminator never shares an edge with the slot that should serve it
	task automatic send(input string s);
		do @(posedge clk_i); while (slot_i !== 1'b1);
		for (int i = 0; i <= s.len(); i++) begin
			@(posedge clk_i);
			rx_valid_i <= 1;
			rx_data_i <= (i == s.len()) ? gmcc_pkg::GMCC_CR : s[i];
			@(posedge clk_i);
			rx_valid_i <= 0;
		end
	endtask
	// next framer start with its kind and drop flag
	task automatic wstart();
		int n;
		n = 0;
		do @(negedge clk_i); while (dg_start_o !== 1'b1 && ++n < 300);
		k = dg_kind_o;
		dr = drop_incr_o;
		if (n >= 300) miscompares++;
	endtask
	task automatic catch_pulse(ref logic s);
		seen = 0;
		repeat (10) begin
			@(negedge clk_i);
			seen |= s;
		end
	endtask
	function automatic gmcc_pkg::gmcc_kind_t kind_of(input byte c);
		return (c == "N") ? gmcc_pkg::GMCC_DG_PARTNO : (c == "I") ? gmcc_pkg::GMCC_DG_SERIAL : gmcc_pkg::GMCC_DG_CONFIG;
	endfunction
	task automatic tally_and_finish();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard, over ten times the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		void'($urandom(90));
		svc = $sformatf("%s", gmcc_pkg::GMCC_STR_SVC);
		bad[2] = {svc, "X"};
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		`CHK(mode_o, gmcc_pkg::GMCC_NORMAL)
		wb(0, gmcc_pkg::GMCC_OFS_LATENCY, 0, 4'hf);
		`CHK(rd, 32'h0)
		// latency round trip; a write to a hole must not land
		lat = 16'($urandom);
		wb(1, gmcc_pkg::GMCC_OFS_LATENCY, {16'h0, lat}, 4'h3);
		wb(1, 8'h40, 32'hffffffff, 4'hf);
		wb(0, gmcc_pkg::GMCC_OFS_LATENCY, 0, 4'hf);
		`CHK(rd, {16'h0, lat})
		`CHK(latency_o, {lat[15:8], lat[7:0]})
		// random fault set shows live, clears, stays accumulated
		f = 8'($urandom) | 8'h01;
		fault_i <= f;
		repeat (3) @(posedge clk_i);
		wb(0, gmcc_pkg::GMCC_OFS_STATUS, 0, 4'hf);
		`CHK(rd[9:0], {gmcc_pkg::GMCC_NORMAL, f})
		fault_i <= '0;
		repeat (3) @(posedge clk_i);
		wb(0, gmcc_pkg::GMCC_OFS_STATUS, 0, 4'hf);
		`CHK(rd[7:0], 8'h00)
		wb(0, gmcc_pkg::GMCC_OFS_LASTERR, 0, 4'hf);
		`CHK(rd[7:0], f)
		wb(0, gmcc_pkg::GMCC_OFS_ERRACC, 0, 4'hf);
		`CHK(rd[7:0], f)
		send("E");
		wstart();
		`CHK(k, gmcc_pkg::GMCC_DG_EXTERR)
		repeat (100) @(posedge clk_i);
		wb(0, gmcc_pkg::GMCC_OFS_ERRACC, 0, 4'hf);
		`CHK(rd[7:0], 8'h00)
		// specials replace one slot, the following measurement drops its increment
		wb(1, gmcc_pkg::GMCC_OFS_CTRL, 32'h1, 4'h1);
		wb(0, gmcc_pkg::GMCC_OFS_CTRL, 0, 4'hf);
		`CHK(rd, 32'h1)
		foreach (cmds[i]) begin
			send(cmds[i]);
			wstart();
			`CHK(k, kind_of(cmds[i][0]))
			wstart();
			`CHK({k, dr}, {gmcc_pkg::GMCC_DG_MEAS, 1'b1})
		end
		// bad input is dropped and the buffer starts afresh
		foreach (bad[i]) begin
			send(bad[i]);
			wstart();
			`CHK(k, gmcc_pkg::GMCC_DG_MEAS)
		end
		send("N");
		wstart();
		`CHK(k, gmcc_pkg::GMCC_DG_PARTNO)
		// maintenance entry, then the two exits and the pin
		for (int i = 0; i < 3; i++) begin
			send(svc);
			wstart();
			`CHK({k, mode_o, discard_o, sampling_en_o}, {gmcc_pkg::GMCC_DG_INFO, gmcc_pkg::GMCC_SERVICE, 2'b11})
			repeat (100) @(posedge clk_i);
			if (i == 2) begin
				// pin held across the sync stages, released on a rising edge
				ext_reset_i <= 1;
				catch_pulse(cfg_reload_o);
				@(posedge clk_i);
				ext_reset_i <= 0;
			end else begin
				wb(1, gmcc_pkg::GMCC_OFS_CTRL, {29'h0, i[0], 2'b10}, 4'h1);
				catch_pulse(cfg_reload_o);
			end
			`CHK({seen, mode_o}, {i[0] || i[1], gmcc_pkg::GMCC_NORMAL})
		end
		wb(0, gmcc_pkg::GMCC_OFS_LATENCY, 0, 4'hf);
		// latency is a bus-written register, not flash configuration, so it outlives every exit
		`CHK(rd[15:0], lat)
		send("R");
		catch_pulse(unit_reset_o);
		`CHK(seen, 1'b1)
		tally_and_finish();
	end
endmodule
